// ===== src/pst_trigger.sv
// I/O trap power-state trigger: configuration registers, three port
// monitors and the stop-clock sequencer.
// Assumes config and I/O strobes are synchronous one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

module pst_trigger
    import pst_pkg::*;
(
    // Clock and reset
    input  wire logic                          SYS_CLK,
    input  wire logic                          RST,
    // Configuration access
    input  wire logic [pst_pkg::ADDR_W-1:0]    CFG_ADDR,
    input  wire logic                          CFG_WR,
    input  wire logic                          CFG_RD,
    input  wire logic [3:0]                    CFG_BE,
    input  wire logic [31:0]                   CFG_WDATA,
    output logic      [31:0]                   CFG_RDATA,
    output logic                               CFG_RVALID,
    // Observed processor I/O cycles
    input  wire logic                          IO_VALID,
    input  wire logic                          IO_WRITE,
    input  wire logic [pst_pkg::DATA_W-1:0]    IO_ADDR,
    input  wire logic [pst_pkg::DATA_W-1:0]    IO_DATA,
    // Stop-clock signalling
    input  wire logic                          STOP_CLOCK_REQUEST_N,
    output logic      [pst_pkg::MON_COUNT-1:0] ARMED,
    output logic      [pst_pkg::MON_COUNT-1:0] ENTER_STATE
);
    import pst_pkg::*;

    // ========================================================================
    // Register storage and monitors
    // Each monitor owns two dwords: port and mask in the first, compare
    // value and control in the second. Byte enables pick the lanes, so one
    // 16-bit field can be rewritten without touching its neighbour.
    // Register writes never touch the armed flags: only a stop-clock
    // assertion or bus reset consumes a pending transition.
    logic [DATA_W-1:0]    port_q [MON_COUNT];
    logic [DATA_W-1:0]    mask_q [MON_COUNT];
    logic [DATA_W-1:0]    cmp_q  [MON_COUNT];
    logic [CTL_W-1:0]     ctl_q  [MON_COUNT];
    logic [MON_COUNT-1:0] hit;
    logic [MON_COUNT-1:0] sel_pm;
    logic [MON_COUNT-1:0] sel_cc;

    genvar g;
    generate
        for (g = 0; g < MON_COUNT; g++) begin : g_mon
            // Carrier for this monitor's configuration and hit
            pst_mon_if mif ();

            // Dword decode for this monitor
            assign sel_pm[g] = (CFG_ADDR[7:2] == OFF_PORT_MASK[g][7:2]);
            assign sel_cc[g] = (CFG_ADDR[7:2] == OFF_CMP_CTL[g][7:2]);

            // Port address and mask, byte lanes 0..3
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    port_q[g] <= RESET_WORD;
                    mask_q[g] <= RESET_WORD;
                end else if (CFG_WR && sel_pm[g]) begin
                    if (CFG_BE[0]) port_q[g][7:0]  <= CFG_WDATA[7:0];
                    if (CFG_BE[1]) port_q[g][15:8] <= CFG_WDATA[15:8];
                    if (CFG_BE[2]) mask_q[g][7:0]  <= CFG_WDATA[23:16];
                    if (CFG_BE[3]) mask_q[g][15:8] <= CFG_WDATA[31:24];
                end
            end

            // Compare value and control; byte 3 and control 7:2 reserved
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    cmp_q[g] <= RESET_WORD;
                    ctl_q[g] <= RESET_CTL;
                end else if (CFG_WR && sel_cc[g]) begin
                    if (CFG_BE[0]) cmp_q[g][7:0]  <= CFG_WDATA[7:0];
                    if (CFG_BE[1]) cmp_q[g][15:8] <= CFG_WDATA[15:8];
                    if (CFG_BE[2]) ctl_q[g] <= CFG_WDATA[17:16];
                end
            end

            // Registers out to the monitor, hit back in
            assign mif.port = port_q[g];
            assign mif.mask = mask_q[g];
            assign mif.cmp  = cmp_q[g];
            assign mif.ctl  = ctl_q[g];
            assign hit[g]   = mif.hit;

            // Address, direction and masked data compare
            pst_port_monitor u_mon (
                .io_valid (IO_VALID),
                .io_write (IO_WRITE),
                .io_addr  (IO_ADDR),
                .io_data  (IO_DATA),
                .cfg      (mif.mon)
            );
        end
    endgenerate

    // ========================================================================
    // Read-back
    // Reserved control bits and the top byte of the compare dword read zero;
    // decode ignores address bits 1:0, so any byte offset hits its dword.
    logic [31:0] next_rdata;

    // Mux the addressed dword, unmapped reads return zero
    always_comb begin
        next_rdata = RESET_RDATA;
        for (int m = 0; m < MON_COUNT; m++) begin
            if (sel_pm[m]) begin
                next_rdata = {mask_q[m], port_q[m]};
            end
            if (sel_cc[m]) begin
                next_rdata = {8'h00, 6'h00, ctl_q[m], cmp_q[m]};
            end
        end
    end

    // Registered read answer, one cycle after the strobe
    // Read data holds between reads; the valid flag marks the answer cycle
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CFG_RDATA  <= RESET_RDATA;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RVALID <= CFG_RD;
            if (CFG_RD) begin
                CFG_RDATA <= next_rdata;
            end
        end
    end

    // ========================================================================
    // Stop-clock sequencer
    // Assertion is the falling edge of the active-low stop-clock line. The
    // history flop resets to the idle (high) level, so no false edge follows
    // reset, while a line already low at release still counts as assertion.
    // Several armed monitors collapse to the deepest state; all are consumed.
    logic                 stop_n_prev;
    logic                 stop_fall;
    logic [MON_COUNT-1:0] next_armed;
    pst_state_t           state;

    // One-clock pulse on each assertion of the stop-clock line
    assign stop_fall = stop_n_prev && !STOP_CLOCK_REQUEST_N;

    // Previous stop-clock level for edge detection
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            stop_n_prev <= 1'b1;
        end else begin
            stop_n_prev <= STOP_CLOCK_REQUEST_N;
        end
    end

    // Armed flags: consumed at assertion, a new hit in that cycle survives
    always_comb begin
        next_armed = ARMED;
        if (stop_fall) begin
            next_armed = NONE_ARMED;
        end
        next_armed = next_armed | hit;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ARMED <= NONE_ARMED;
        end else begin
            ARMED <= next_armed;
        end
    end

    // Transition pulse at the next stop-clock assertion, deepest wins
    // Only one bit pulses, for a single clock
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ENTER_STATE <= NONE_ARMED;
        end else begin
            ENTER_STATE <= NONE_ARMED;
            if (stop_fall) begin
                if (ARMED[MON_SUSPEND]) begin
                    ENTER_STATE[MON_SUSPEND] <= 1'b1;
                end else if (ARMED[MON_LEVEL3]) begin
                    ENTER_STATE[MON_LEVEL3] <= 1'b1;
                end else if (ARMED[MON_LEVEL2]) begin
                    ENTER_STATE[MON_LEVEL2] <= 1'b1;
                end
            end
        end
    end

    // Summary state for observation
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= PST_IDLE;
        end else begin
            unique case (state)
                PST_IDLE:  if (|next_armed) state <= PST_ARMED;
                PST_ARMED: if (stop_fall && |ARMED) state <= PST_ENTER;
                PST_ENTER: state <= (|next_armed) ? PST_ARMED : PST_IDLE;
                default:   state <= PST_IDLE;                     // Unused code
            endcase
        end
    end
endmodule

`default_nettype wire

// ===== src/pst_pkg.sv
// Constants for the I/O trap power-state trigger.
// Assumes byte offsets in configuration space, 32-bit dword access.
package pst_pkg;

    // ========================================================================
    // Geometry
    localparam int          MON_COUNT   = 3;
    localparam int          DATA_W      = 16;
    localparam int          ADDR_W      = 8;
    localparam int          CTL_W       = 2;

    // ========================================================================
    // Monitor indices, deepest state has the highest index
    localparam int          MON_LEVEL2  = 0;
    localparam int          MON_LEVEL3  = 1;
    localparam int          MON_SUSPEND = 2;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0]  OFF_LEVEL2_PORT_ADDRESS      = 8'hE0;
    localparam logic [7:0]  OFF_LEVEL2_DATA_MASK         = 8'hE2;
    localparam logic [7:0]  OFF_LEVEL2_COMPARE_VALUE     = 8'hE4;
    localparam logic [7:0]  OFF_LEVEL2_MONITOR_CONTROL   = 8'hE6;
    localparam logic [7:0]  OFF_LEVEL3_PORT_ADDRESS      = 8'hE8;
    localparam logic [7:0]  OFF_LEVEL3_DATA_MASK         = 8'hEA;
    localparam logic [7:0]  OFF_LEVEL3_COMPARE_VALUE     = 8'hEC;
    localparam logic [7:0]  OFF_LEVEL3_MONITOR_CONTROL   = 8'hEE;
    localparam logic [7:0]  OFF_SUSPEND_RAM_PORT_ADDRESS = 8'hF0;
    localparam logic [7:0]  OFF_SUSPEND_RAM_DATA_MASK    = 8'hF2;
    localparam logic [7:0]  OFF_SUSPEND_RAM_COMPARE      = 8'hF4;
    localparam logic [7:0]  OFF_SUSPEND_RAM_CONTROL      = 8'hF6;

    // Dword holding port address (low half) and mask (high half)
    localparam logic [7:0]  OFF_PORT_MASK [MON_COUNT] = '{
        OFF_LEVEL2_PORT_ADDRESS, OFF_LEVEL3_PORT_ADDRESS, OFF_SUSPEND_RAM_PORT_ADDRESS};
    // Dword holding compare value (low half) and control (byte 2)
    localparam logic [7:0]  OFF_CMP_CTL [MON_COUNT] = '{
        OFF_LEVEL2_COMPARE_VALUE, OFF_LEVEL3_COMPARE_VALUE, OFF_SUSPEND_RAM_COMPARE};

    // ========================================================================
    // Control register fields and reset values
    localparam int          CTL_WATCH_READS  = 0;
    localparam int          CTL_WATCH_WRITES = 1;
    localparam logic [15:0] RESET_WORD       = 16'h0000;
    localparam logic [1:0]  RESET_CTL        = 2'h0;
    localparam logic [31:0] RESET_RDATA      = 32'h0000_0000;
    localparam logic [2:0]  NONE_ARMED       = 3'h0;

    // ========================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        PST_IDLE,
        PST_ARMED,
        PST_ENTER
    } pst_state_t;

endpackage

// ===== src/pst_mon_if.sv
// Carrier between the trigger top and one port monitor.
// Assumes the top drives configuration and samples the hit flag.
`timescale 1ns/10ps
`default_nettype none

interface pst_mon_if;
    import pst_pkg::*;

    // Configuration from the register file
    logic [DATA_W-1:0] port;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] cmp;
    logic [CTL_W-1:0]  ctl;
    // Match found on the current I/O cycle
    logic              hit;

    modport top (output port, output mask, output cmp, output ctl, input hit);
    modport mon (input port, input mask, input cmp, input ctl, output hit);
endinterface

`default_nettype wire

// ===== src/pst_port_monitor.sv
// One I/O port monitor: address, direction, masked data compare.
// Assumes I/O cycle strobes are one clock wide and synchronous.
`timescale 1ns/10ps
`default_nettype none

module pst_port_monitor
    import pst_pkg::*;
(
    // I/O cycle observed
    input  wire logic                       io_valid,
    input  wire logic                       io_write,
    input  wire logic [pst_pkg::DATA_W-1:0] io_addr,
    input  wire logic [pst_pkg::DATA_W-1:0] io_data,
    // Configuration and result
    pst_mon_if.mon                          cfg
);
    import pst_pkg::*;

    logic dir_ok;
    logic addr_ok;
    logic data_ok;

    // Direction gate by the watch bits
    assign dir_ok  = io_write ? cfg.ctl[CTL_WATCH_WRITES]
                              : cfg.ctl[CTL_WATCH_READS];
    // Programmed port address match
    assign addr_ok = (io_addr == cfg.port);
    // Masked data against compare value
    assign data_ok = ((io_data & cfg.mask) == cfg.cmp);
    // Only enabled, addressed cycles can hit
    assign cfg.hit = io_valid && addr_ok && dir_ok && data_ok;
endmodule

`default_nettype wire

// ===== sim/pst_trigger_chk.sv
// Checker: port-level timing of the power-state trigger.
// Assumes it is bound into every pst_trigger instance.
`timescale 1ns/10ps
`default_nettype none

module pst_trigger_chk (
    // Clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RST,
    // Configuration access
    input wire logic [7:0]  CFG_ADDR,
    input wire logic        CFG_WR,
    input wire logic        CFG_RD,
    input wire logic [3:0]  CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    input wire logic [31:0] CFG_RDATA,
    input wire logic        CFG_RVALID,
    // I/O cycles and stop-clock
    input wire logic        IO_VALID,
    input wire logic        IO_WRITE,
    input wire logic [15:0] IO_ADDR,
    input wire logic [15:0] IO_DATA,
    input wire logic        STOP_CLOCK_REQUEST_N,
    input wire logic [2:0]  ARMED,
    input wire logic [2:0]  ENTER_STATE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    // ==========
    // Assertions
    rd_answer_a:
        assert property (CFG_RD |=> CFG_RVALID) else $error("read not answered");
    rd_quiet_a:
        assert property (!CFG_RD |=> !CFG_RVALID) else $error("stray read answer");
    enter_cause_a:
        assert property (ENTER_STATE != 0 |-> $past(ARMED) != 0 && !$past(STOP_CLOCK_REQUEST_N))
        else $error("transition without cause");
    enter_fire_a:
        assert property ($fell(STOP_CLOCK_REQUEST_N) && ARMED != 0 |=> ENTER_STATE != 0)
        else $error("armed transition not taken");
    enter_pulse_a:
        assert property (ENTER_STATE != 0 |=> ENTER_STATE == 0) else $error("long pulse");
    deepest_wins_a:
        assert property ($fell(STOP_CLOCK_REQUEST_N) && ARMED[2] |=> ENTER_STATE == 3'h4)
        else $error("suspend not preferred");
    one_enter_a:
        assert property ($onehot0(ENTER_STATE)) else $error("several transitions");
    arm_clear_a:
        assert property ($fell(STOP_CLOCK_REQUEST_N) && !IO_VALID |=> ARMED == 0)
        else $error("armed not consumed");
    arm_keep_a:
        assert property (!$fell(STOP_CLOCK_REQUEST_N) |=> (ARMED & $past(ARMED)) == $past(ARMED))
        else $error("armed lost");
    arm_cause_a:
        assert property ((ARMED & ~$past(ARMED)) != 0 |-> $past(IO_VALID))
        else $error("armed without cycle");

    // Main scenarios reached
    cover property (ENTER_STATE == 3'h1);
    cover property (ENTER_STATE == 3'h2);
    cover property (ENTER_STATE == 3'h4);
endmodule

bind pst_trigger pst_trigger_chk chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .CFG_ADDR(CFG_ADDR), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
    .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
    .IO_VALID(IO_VALID), .IO_WRITE(IO_WRITE), .IO_ADDR(IO_ADDR), .IO_DATA(IO_DATA),
    .STOP_CLOCK_REQUEST_N(STOP_CLOCK_REQUEST_N), .ARMED(ARMED), .ENTER_STATE(ENTER_STATE));

`default_nettype wire

// ===== sim/pst_cpu_model.sv
// Processor side: I/O cycles and the stop-clock line.
// Assumes the bench calls its tasks; drives at the falling edge.
`timescale 1ns/10ps
`default_nettype none

module pst_cpu_model (
    // Clock
    input  wire logic   clk,
    // I/O cycles and stop-clock
    output logic        io_valid,
    output logic        io_write,
    output logic [15:0] io_addr,
    output logic [15:0] io_data,
    output logic        stop_clock_request_n
);
    // Idle, stop-clock deasserted
    initial begin
        io_valid = 1'b0;
        io_write = 1'b0;
        io_addr  = 16'h0000;
        io_data  = 16'h0000;
        stop_clock_request_n = 1'b1;
    end

    // One-clock I/O cycle; idle bus then shows inverted values
    task automatic cycle(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        io_valid = 1'b1;
        io_write = wr;
        io_addr  = a;
        io_data  = d;
        @(negedge clk);
        io_valid = 1'b0;
        io_write = ~wr;
        io_addr  = ~a;
        io_data  = ~d;
    endtask

    // Stop-clock assertion and release
    task automatic stop_low();
        @(negedge clk);
        stop_clock_request_n = 1'b0;
        @(negedge clk);
    endtask
    task automatic stop_high();
        stop_clock_request_n = 1'b1;
        @(negedge clk);
    endtask
endmodule

`default_nettype wire

// ===== sim/pst_trigger_bench.sv
// Bench for the power-state trigger: registers, monitors, stop-clock.
// Assumes pst_cpu_model drives the I/O side.
`timescale 1ns/10ps
`default_nettype none

module pst_trigger_bench;
    import pst_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  cfg_addr = 8'h00;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [3:0]  cfg_be = 4'hF;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] rdata;
    logic        rvalid;
    logic        io_valid;
    logic        io_write;
    logic [15:0] io_addr;
    logic [15:0] io_data;
    logic        stop_n;
    logic [2:0]  armed;
    logic [2:0]  enter;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    pst_trigger uut (.SYS_CLK(clk), .RST(rst), .CFG_ADDR(cfg_addr), .CFG_WR(cfg_wr),
        .CFG_RD(cfg_rd), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .CFG_RDATA(rdata),
        .CFG_RVALID(rvalid), .IO_VALID(io_valid), .IO_WRITE(io_write), .IO_ADDR(io_addr),
        .IO_DATA(io_data), .STOP_CLOCK_REQUEST_N(stop_n), .ARMED(armed), .ENTER_STATE(enter));
    pst_cpu_model cpu (.clk(clk), .io_valid(io_valid), .io_write(io_write),
        .io_addr(io_addr), .io_data(io_data), .stop_clock_request_n(stop_n));

    // Clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ==========
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask
    task automatic prog(input int m, input logic [15:0] p, k, c, input logic [1:0] ctl);
        wr(OFF_PORT_MASK[m], {k, p});
        wr(OFF_CMP_CTL[m], {14'h0, ctl, c});
    endtask
    task automatic fire(input logic [2:0] exp);
        cpu.stop_low();
        check(enter, exp);
        check(armed, 3'h0);
        cpu.stop_high();
    endtask

    // ==========
    // Scenarios
    task automatic t_regs();
        for (int a = 32'hE0; a <= 32'hF8; a += 4) rd(a[7:0], 32'h0);
        wr(8'hE4, 32'hFFFF_FFFF);
        rd(8'hE4, 32'h0003_FFFF);
        wr(8'hF8, 32'hFFFF_FFFF);
        rd(8'hF8, 32'h0);
        wr(8'hE4, 32'h0);
        cfg_be = 4'h5;
        wr(OFF_LEVEL2_PORT_ADDRESS, 32'h1234_5678);
        rd(OFF_LEVEL2_PORT_ADDRESS, 32'h0034_0078);
        cfg_be = 4'hF;
        wr(OFF_LEVEL2_PORT_ADDRESS, 32'h0);
    endtask
    task automatic t_reset();
        prog(MON_LEVEL3, 16'h0080, 16'hFFFF, 16'h0002, 2'b10);
        rd(OFF_LEVEL3_PORT_ADDRESS, 32'hFFFF_0080);
        cpu.cycle(1'b1, 16'h0080, 16'h0002);
        check(armed, 3'h2);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check(armed, 3'h0);
        check(rdata, 32'h0);
        check(rvalid, 1'b0);
        rd(OFF_LEVEL3_PORT_ADDRESS, 32'h0);
        rd(OFF_LEVEL3_COMPARE_VALUE, 32'h0);
        fire(3'h0);
    endtask
    task automatic t_mon(input int m);
        logic [15:0] p;
        p = 16'hB200 + 16'(m);
        prog(m, p, 16'h0FF0, 16'h0A50, 2'b10);
        cpu.cycle(1'b0, p, 16'hFA5F);
        check(armed, 3'h0);
        cpu.cycle(1'b1, p ^ 16'h8000, 16'hFA5F);
        check(armed, 3'h0);
        cpu.cycle(1'b1, p, 16'h0A40);
        check(armed, 3'h0);
        cpu.cycle(1'b1, p, 16'hFA5F);
        check(armed, 3'h1 << m);
        fire(3'h1 << m);
        prog(m, p, 16'h0FF0, 16'h0A50, 2'b01);
        cpu.cycle(1'b0, p, 16'h0A5F);
        check(armed, 3'h1 << m);
        fire(3'h1 << m);
        prog(m, p, 16'h0FF0, 16'h0A50, 2'b00);
    endtask
    task automatic t_deep();
        prog(MON_LEVEL2, 16'h0070, 16'hFFFF, 16'h0001, 2'b11);
        prog(MON_SUSPEND, 16'h0070, 16'hFFFF, 16'h0001, 2'b11);
        cpu.cycle(1'b1, 16'h0070, 16'h0001);
        check(armed, 3'h5);
        fire(3'h4);
        fire(3'h0);
    endtask

    // Verdict and end of run
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_regs();
        for (int m = 0; m < MON_COUNT; m++) t_mon(m);
        t_deep();
        t_reset();
        print_verdict();
    end
endmodule

`default_nettype wire
